// ===== rtl/sahp_defines.svh
// sahp_defines.svh: timing and layout constants for the serial A/D host port.
// assumes clk_sys at 200 MHz; included by its bare name.
`ifndef SAHP_DEFINES_SVH
`define SAHP_DEFINES_SVH

`define SAHP_CLK_HZ 200000000
// device limits, in Hz
`define SAHP_SYSCLK_MAX_HZ 4000000
`define SAHP_IOCLK_MAX_HZ 2100000
// conversion length, in converter system clock cycles
`define SAHP_CONV_SYSCLKS 36
// half periods round up so neither clock ever runs above its limit
`define SAHP_SYS_HALF_CYC ((`SAHP_CLK_HZ + 2 * `SAHP_SYSCLK_MAX_HZ - 1) / (2 * `SAHP_SYSCLK_MAX_HZ))
`define SAHP_IO_HALF_CYC ((`SAHP_CLK_HZ + 2 * `SAHP_IOCLK_MAX_HZ - 1) / (2 * `SAHP_IOCLK_MAX_HZ))
`define SAHP_CONV_CYC (`SAHP_CONV_SYSCLKS * 2 * `SAHP_SYS_HALF_CYC)
// transfer layout
`define SAHP_BYTE_W 8
`define SAHP_CHAN_W 5
`define SAHP_CNT_W 11
`define SAHP_DIV_W 5
`define SAHP_LAST_BIT 3'h7

`endif

// ===== rtl/sahp_pkg.sv
// sahp_pkg: types of the serial A/D host port.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package sahp_pkg;
   typedef enum logic [2:0] {
      SAHP_IDLE,
      SAHP_SETUP,
      SAHP_HIGH,
      SAHP_TAIL,
      SAHP_CONV
   } sahp_state_t;
endpackage : sahp_pkg

`default_nettype wire

// ===== rtl/sahp_clk_div.sv
// sahp_clk_div: free-running divider making the converter system clock.
// assumes clk_sys at 200 MHz and a synchronous active-high reset.
`include "sahp_defines.svh"
`default_nettype none

module sahp_clk_div (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   output logic clk_out
);
   import sahp_pkg::*;

   logic [`SAHP_DIV_W-1:0] cnt_r;
   logic [`SAHP_DIV_W-1:0] cnt_nxt;
   logic clk_out_r;
   logic clk_out_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      clk_out_nxt = clk_out_r;
      if (cnt_r == `SAHP_DIV_W'(`SAHP_SYS_HALF_CYC - 1)) begin
         cnt_nxt = '0;
         clk_out_nxt = ~clk_out_r;
      end else begin
         cnt_nxt = cnt_r + `SAHP_DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_r <= '0;
         clk_out_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         clk_out_r <= clk_out_nxt;
      end
   end

   assign clk_out = clk_out_r;
endmodule : sahp_clk_div

`default_nettype wire

// ===== rtl/sahp_host.sv
// sahp_host: host controller driving an 8-bit serial multichannel A/D converter.
// assumes clk_sys at 200 MHz, synchronous active-high rst, data_out asynchronous.
//
// Behaviour
// - channel in top five bits, MSB first
// - address out and result in simultaneously
// - one address bit, one result bit per clock
// - result shifted left, first bit ends MSB
// - wait 36 system clocks before next transfer
// - chip select high after eighth fall, during conversion
// - system clock <=4 MHz, I/O clock <=2.1 MHz
// - write asserts select and loads shift register
// - start then gates I/O clock to converter
// - after eighth fall stop clock, drop select
// - previous result readable during conversion
// - chip select driven from a flip-flop
`include "sahp_defines.svh"
`default_nettype none

module sahp_host (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [`SAHP_BYTE_W-1:0] start_byte,
   output logic ready,
   output logic [`SAHP_BYTE_W-1:0] result,
   output logic result_valid,
   output logic cs_n,
   output logic io_clk,
   output logic addr_in,
   input wire logic data_out,
   output logic adc_sys_clk
);
   import sahp_pkg::*;

   function automatic logic sahp_hit(input logic [`SAHP_CNT_W-1:0] c, input int lim);
      sahp_hit = (c == `SAHP_CNT_W'(lim - 1));
   endfunction : sahp_hit

   function automatic logic [`SAHP_CNT_W-1:0] sahp_inc(input logic [`SAHP_CNT_W-1:0] c);
      sahp_inc = c + `SAHP_CNT_W'(1);
   endfunction : sahp_inc

   // one left shift step, new bit enters at the bottom
   function automatic logic [`SAHP_BYTE_W-1:0] sahp_shl(input logic [`SAHP_BYTE_W-1:0] v, input logic b);
      sahp_shl = {v[`SAHP_BYTE_W-2:0], b};
   endfunction : sahp_shl

   // data_out synchroniser: first stage feeds only the second
   logic din_meta_r;
   logic din_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         din_meta_r <= 1'b0;
         din_r <= 1'b0;
      end else if (ce) begin
         din_meta_r <= data_out;
         din_r <= din_meta_r;
      end
   end

   // converter system clock, free running and unrelated to io_clk
   sahp_clk_div u_sysclk (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .clk_out(adc_sys_clk)
   );

   sahp_state_t st_r;
   sahp_state_t st_nxt;
   logic [`SAHP_CNT_W-1:0] cnt_r;
   logic [`SAHP_CNT_W-1:0] cnt_nxt;
   logic [2:0] bit_r;
   logic [2:0] bit_nxt;
   logic [`SAHP_BYTE_W-1:0] addr_sh_r;
   logic [`SAHP_BYTE_W-1:0] addr_sh_nxt;
   logic [`SAHP_BYTE_W-1:0] res_sh_r;
   logic [`SAHP_BYTE_W-1:0] res_sh_nxt;
   logic [`SAHP_BYTE_W-1:0] result_r;
   logic [`SAHP_BYTE_W-1:0] result_nxt;
   logic valid_r;
   logic valid_nxt;
   logic ready_r;
   logic ready_nxt;
   logic cs_n_r;
   logic cs_n_nxt;
   logic io_clk_r;
   logic io_clk_nxt;
   logic addr_in_r;
   logic addr_in_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      addr_sh_nxt = addr_sh_r;
      res_sh_nxt = res_sh_r;
      result_nxt = result_r;
      valid_nxt = 1'b0;
      ready_nxt = ready_r;
      cs_n_nxt = cs_n_r;
      io_clk_nxt = io_clk_r;
      addr_in_nxt = addr_in_r;
      case (st_r)
         SAHP_IDLE: begin
            if (start) begin
               // channel sits in the top five bits and leaves MSB first
               addr_sh_nxt = start_byte;
               addr_in_nxt = start_byte[`SAHP_BYTE_W-1];
               cs_n_nxt = 1'b0;
               bit_nxt = 3'h0;
               cnt_nxt = '0;
               ready_nxt = 1'b0;
               st_nxt = SAHP_SETUP;
            end
         end
         SAHP_SETUP: begin
            // low half: address bit settles, result bit is sampled before the rise
            if (sahp_hit(cnt_r, `SAHP_IO_HALF_CYC)) begin
               cnt_nxt = '0;
               io_clk_nxt = 1'b1;
               res_sh_nxt = sahp_shl(res_sh_r, din_r);
               st_nxt = SAHP_HIGH;
            end else begin
               cnt_nxt = sahp_inc(cnt_r);
            end
         end
         SAHP_HIGH: begin
            if (sahp_hit(cnt_r, `SAHP_IO_HALF_CYC)) begin
               cnt_nxt = '0;
               io_clk_nxt = 1'b0;
               // next address bit changes on the same clk_sys edge as the fall, keeping hold on the rise
               addr_sh_nxt = sahp_shl(addr_sh_r, 1'b0);
               addr_in_nxt = addr_sh_r[`SAHP_BYTE_W-2];
               if (bit_r == `SAHP_LAST_BIT) begin
                  result_nxt = res_sh_r;
                  valid_nxt = 1'b1;
                  st_nxt = SAHP_TAIL;
               end else begin
                  bit_nxt = bit_r + 3'h1;
                  st_nxt = SAHP_SETUP;
               end
            end else begin
               cnt_nxt = sahp_inc(cnt_r);
            end
         end
         SAHP_TAIL: begin
            // select rises a half period after the eighth fall, never on it
            if (sahp_hit(cnt_r, `SAHP_IO_HALF_CYC)) begin
               cnt_nxt = '0;
               cs_n_nxt = 1'b1;
               st_nxt = SAHP_CONV;
            end else begin
               cnt_nxt = sahp_inc(cnt_r);
            end
         end
         SAHP_CONV: begin
            // counted from select rise, so the converter always gets its full 36 clocks
            if (sahp_hit(cnt_r, `SAHP_CONV_CYC)) begin
               cnt_nxt = '0;
               ready_nxt = 1'b1;
               st_nxt = SAHP_IDLE;
            end else begin
               cnt_nxt = sahp_inc(cnt_r);
            end
         end
         default: begin
            st_nxt = SAHP_IDLE;
            cnt_nxt = '0;
            ready_nxt = 1'b1;
            cs_n_nxt = 1'b1;
            io_clk_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= SAHP_IDLE;
         cnt_r <= '0;
         bit_r <= 3'h0;
         addr_sh_r <= '0;
         res_sh_r <= '0;
         result_r <= '0;
         valid_r <= 1'b0;
         ready_r <= 1'b1;
         cs_n_r <= 1'b1;
         io_clk_r <= 1'b0;
         addr_in_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         addr_sh_r <= addr_sh_nxt;
         res_sh_r <= res_sh_nxt;
         result_r <= result_nxt;
         valid_r <= valid_nxt;
         ready_r <= ready_nxt;
         cs_n_r <= cs_n_nxt;
         io_clk_r <= io_clk_nxt;
         addr_in_r <= addr_in_nxt;
      end
   end

   assign ready = ready_r;
   assign result = result_r;
   assign result_valid = valid_r;
   assign cs_n = cs_n_r;
   assign io_clk = io_clk_r;
   assign addr_in = addr_in_r;
endmodule : sahp_host

`default_nettype wire

// ===== sim/sahp_host_properties.sv
// sahp_host_properties: pin timing checks for the host port.
// assumes it is bound into sahp_host; ce held high.
`default_nettype none
module sahp_host_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire logic ready,
   input wire logic [7:0] result,
   input wire logic result_valid,
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic addr_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic io_d_r;
   logic [3:0] pls_r, pls_nxt;
   logic [11:0] hi_r, hi_nxt;
   always_comb begin
      pls_nxt = cs_n ? 4'h0 : pls_r + {3'h0, io_clk & ~io_d_r};
      hi_nxt = cs_n ? hi_r + {11'h0, hi_r != 12'hfff} : 12'h000;
   end
   // starts saturated so the first select after reset is legal
   always_ff @(posedge clk_sys) begin
      io_d_r <= rst ? 1'b0 : io_clk;
      pls_r <= rst ? 4'h0 : pls_nxt;
      hi_r <= rst ? 12'hfff : hi_nxt;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence last_fall;
      $fell(io_clk) && pls_r == 4'h8;
   endsequence
   frame_end_a: assert property (last_fall |-> result_valid ##48 $rose(cs_n))
      else $error("late select release");
   idle_clk_a: assert property (cs_n |-> !io_clk)
      else $error("io_clk high while deselected");
   clk_high_a: assert property ($rose(io_clk) |-> ##48 $fell(io_clk))
      else $error("io_clk high time wrong");
   clk_low_a: assert property ($fell(io_clk) && pls_r != 4'h8 |-> ##48 $rose(io_clk))
      else $error("io_clk low time wrong");
   eight_clk_a: assert property ($rose(cs_n) |-> pls_r == 4'h8)
      else $error("pulse count not eight");
   conv_gap_a: assert property ($fell(cs_n) |-> hi_r >= 12'h708)
      else $error("select reasserted too soon");
   addr_hold_a: assert property (!cs_n && !$fell(io_clk) && !$fell(cs_n) |-> $stable(addr_in))
      else $error("addr_in moved off a falling edge");
   take_start_a: assert property (start && ready |=> !ready && !cs_n)
      else $error("start not taken");
   result_hold_a: assert property (!result_valid |-> $stable(result))
      else $error("result moved without valid");
endmodule : sahp_host_chk
bind sahp_host sahp_host_chk u_chk (.clk_sys(clk_sys), .rst(rst), .start(start), .ready(ready),
   .result(result), .result_valid(result_valid), .cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in));
`default_nettype wire

// ===== sim/sahp_adc_model.sv
// sahp_adc_model: behavioural 8-bit serial converter on the far side.
// assumes host-made io_clk and adc_sys_clk; power-up result 8'hc3.
`default_nettype none
module sahp_adc_model (
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic addr_in,
   input wire logic adc_sys_clk,
   output logic data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] res_r = 8'hc3;
   logic [7:0] sh_r = 8'h00;
   logic [7:0] ain_r = 8'h00;
   logic [4:0] ch_r = 5'h00;
   logic [2:0] cnt_r = 3'h0;
   int conv_r = 36;
   bit early_r = 1'b0;
   bit smp_r = 1'b0;
   // inverse when deselected so a stale bit never looks valid
   assign data_out = cs_n ? ~sh_r[7] : sh_r[7];
   always @(negedge cs_n) begin
      early_r |= conv_r < 36;
      sh_r = res_r;
      cnt_r = 3'h0;
      smp_r = 1'b0;
   end
   always @(posedge io_clk) if (!cs_n) ain_r = {ain_r[6:0], addr_in};
   always @(negedge io_clk) if (!cs_n) begin
      sh_r = {sh_r[6:0], 1'b0};
      // sampling window opens at the fourth fall
      if (cnt_r == 3'h3) smp_r = 1'b1;
      if (cnt_r == 3'h7) begin
         if (smp_r) ch_r = ain_r[7:3];
         smp_r = 1'b0;
         conv_r = 0;
      end
      cnt_r++;
   end
   always @(posedge adc_sys_clk) if (conv_r < 36) begin
      conv_r++;
      if (conv_r == 36) res_r = {ch_r, 3'h5};
   end
endmodule : sahp_adc_model
`default_nettype wire

// ===== sim/tb.sv
// tb: self-checking bench for sahp_host with a converter model.
// assumes model and checker compiled first.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] start_byte = 8'h00;
   logic ready, result_valid, cs_n, io_clk, addr_in, data_out, adc_sys_clk;
   logic [7:0] result;
   int n_errors = 0;
   int tests_run = 0;
   int n_rise = 0;
   logic [7:0] rows [5][2] = '{'{8'h00, 8'hc3}, '{8'h90, 8'h05}, '{8'h98, 8'h95}, '{8'h58, 8'h9d},
      '{8'hf8, 8'h5d}};
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge io_clk) n_rise++;
   sahp_host u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .start(start), .start_byte(start_byte),
      .ready(ready), .result(result), .result_valid(result_valid), .cs_n(cs_n), .io_clk(io_clk),
      .addr_in(addr_in), .data_out(data_out), .adc_sys_clk(adc_sys_clk));
   sahp_adc_model u_adc (.cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in), .adc_sys_clk(adc_sys_clk),
      .data_out(data_out));
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic end_sim;
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic wait_hi(input bit use_valid);
      int i;
      for (i = 0; i < 4000 && (use_valid ? result_valid : ready) !== 1'b1; i++) @(negedge clk_sys);
      if (i == 4000) begin
         n_errors++;
         end_sim();
      end
   endtask : wait_hi
   // start held a second cycle: the busy host must ignore it
   task automatic xfer(input logic [7:0] b, input logic [7:0] exp);
      wait_hi(1'b0);
      n_rise = 0;
      start = 1'b1;
      start_byte = b;
      @(negedge clk_sys);
      check("ready", 8'h00, {7'h0, ready});
      @(negedge clk_sys);
      start = 1'b0;
      wait_hi(1'b1);
      check("result", exp, result);
      check("channel", {3'h0, b[7:3]}, {3'h0, u_adc.ch_r});
      check("io_clk count", 8'h08, n_rise[7:0]);
      @(negedge clk_sys);
      check("valid", 8'h00, {7'h0, result_valid});
   endtask : xfer
   initial begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      check("result reset", 8'h00, result);
      check("cs_n reset", 8'h01, {7'h0, cs_n});
      for (int i = 0; i < 5; i++) xfer(rows[i][0], rows[i][1]);
      check("early conv", 8'h00, {7'h0, u_adc.early_r});
      // reset mid-frame while io_clk is low, so no edge race
      wait_hi(1'b0);
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      repeat (300) @(negedge clk_sys);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      check("cs_n abort", 8'h01, {7'h0, cs_n});
      check("ready abort", 8'h01, {7'h0, ready});
      xfer(8'h00, 8'hfd);
      end_sim();
   end
endmodule : tb
`default_nettype wire
